// *** sfx_exc_signal.v ***
// simd fp exception signalling unit: flags, masks, fault and wishbone registers
`timescale 1ns/1ns
`include "sfx_regs.vh"

module sfx_exc_signal (
    // clock and reset
    input  wire                              clk,
    input  wire                              rst_n,
    // operation from the execution datapath
    input  wire                              opValid,
    output wire                              opReady,
    input  wire [`SFX_OP_W-1:0]              opCode,
    input  wire                              immBit3,
    input  wire [`SFX_LANES-1:0]             laneValid,
    input  wire [`SFX_LANES*`SFX_CLS_W-1:0]  laneExc,
    // completion toward writeback and trap dispatch
    output reg                               doneValid,
    output reg                               destWrite,
    output reg                               faultTake,
    output reg  [7:0]                        faultVector,
    output reg  [`SFX_CLS_W-1:0]             faultCause,
    input  wire                              trapAck,
    // wishbone slave
    input  wire                              wb_cyc_i,
    input  wire                              wb_stb_i,
    input  wire                              wb_we_i,
    input  wire [3:0]                        wb_adr_i,
    input  wire [3:0]                        wb_sel_i,
    input  wire [31:0]                       wb_dat_i,
    output reg  [31:0]                       wb_dat_o,
    output reg                               wb_ack_o,
    // interrupt
    output wire                              irq
);

    // one-hot states: accepting ops, or holding a fault for dispatch
    localparam [1:0] ST_RUN   = 2'b01;
    localparam [1:0] ST_FAULT = 2'b10;

    reg  [1:0]                  state;       // current state
    reg  [1:0]                  next_state;  // state for next edge
    reg  [`SFX_CS_W-1:0]        ctrlStat;    // flags and masks
    reg  [`SFX_IRQ_W-1:0]       irqStat;     // sticky interrupt events
    reg  [`SFX_IRQ_W-1:0]       irqMask;     // interrupt enables
    reg  [7:0]                  faultCount;  // faults taken, wraps
    wire [`SFX_CLS_W-1:0]       allowed;     // classes this op may report
    wire [`SFX_CLS_W-1:0]       laneOr [0:`SFX_LANES]; // running lane OR
    wire [`SFX_CLS_W-1:0]       raised;      // classes raised by this op
    wire [`SFX_CLS_W-1:0]       masks;       // mask field of ctrlStat
    wire [`SFX_CLS_W-1:0]       unmasked;    // raised and not masked
    wire                        opFire;      // op accepted this edge
    wire                        wbReq;       // new bus request
    wire                        csWrite;     // software writes ctrlStat
    wire                        irqStRead;   // software reads irqStat
    wire [`SFX_CS_W-1:0]        csByteMask;  // byte lanes of a write
    wire [`SFX_CS_W-1:0]        flagSet;     // hardware flag sets
    wire [`SFX_IRQ_W-1:0]       irqEvent;    // events this edge

    // class filter for the incoming operation
    sfx_class_filter uFilter (
        .opCode  (opCode),
        .immBit3 (immBit3),
        .allowed (allowed)
    );

    // or-reduce lane conditions; lane position is lost on purpose
    assign laneOr[0] = `SFX_CLS_NONE;
    genvar li;
    generate
        for (li = 0; li < `SFX_LANES; li = li + 1) begin : gLane
            // lanes outside the operation's width contribute nothing
            assign laneOr[li+1] = laneOr[li] |
                (laneExc[li*`SFX_CLS_W +: `SFX_CLS_W] &
                 {`SFX_CLS_W{laneValid[li]}});
        end
    endgenerate

    // only classes the operation may report survive
    assign raised   = laneOr[`SFX_LANES] & allowed;
    assign masks    = ctrlStat[`SFX_MASK_LSB +: `SFX_CLS_W];
    // fault decided from this op alone, never from standing flags
    assign unmasked = raised & ~masks;

    // ops are held off while a fault waits for dispatch
    assign opReady = state[0];
    assign opFire  = opValid & opReady;

    // state machine: a fault stays until trap dispatch accepts it
    always @* begin
        case (state)
            ST_RUN: begin
                // any unmasked class means one fault, whatever the count
                if (opFire && (|unmasked)) begin
                    next_state = ST_FAULT;
                end else begin
                    next_state = ST_RUN;
                end
            end
            ST_FAULT: begin
                // released by dispatch acknowledge
                if (trapAck) begin
                    next_state = ST_RUN;
                end else begin
                    next_state = ST_FAULT;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // state register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // completion outputs, one cycle after the op is taken
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doneValid   <= 1'b0;
            destWrite   <= 1'b0;
            faultTake   <= 1'b0;
            faultVector <= 8'h00;
            faultCause  <= `SFX_CLS_NONE;
        end else begin
            doneValid <= opFire;
            // masked or clean: default or real result is written
            destWrite <= opFire & ~(|unmasked);
            // fault belongs to this very instruction, no deferral
            faultTake <= opFire & (|unmasked);
            if (opFire && (|unmasked)) begin
                faultVector <= `SFX_FAULT_VEC;
                faultCause  <= unmasked;
            end
        end
    end

    // fault counter, visible to software
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultCount <= 8'h00;
        end else if (opFire && (|unmasked)) begin
            faultCount <= faultCount + 8'h01;
        end
    end

    // wishbone decode; a request is new while ack is low
    assign wbReq      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign csWrite    = wbReq & wb_we_i & (wb_adr_i[3:2] == `SFX_ADR_CS);
    assign irqStRead  = wbReq & ~wb_we_i & (wb_adr_i[3:2] == `SFX_ADR_IRQST);
    assign csByteMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & `SFX_CS_WMASK;

    // every raised class is flagged, masked or not
    assign flagSet = {{(`SFX_CS_W-`SFX_CLS_W){1'b0}},
                      (opFire ? raised : `SFX_CLS_NONE)};

    // control/status: hardware set wins over a software clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlStat <= `SFX_CS_RESET;
        end else if (csWrite) begin
            ctrlStat <= ((ctrlStat & ~csByteMask) |
                         (wb_dat_i[`SFX_CS_W-1:0] & csByteMask)) | flagSet;
        end else begin
            ctrlStat <= ctrlStat | flagSet;
        end
    end

    // interrupt events: masked flag raised, fault taken
    assign irqEvent[`SFX_IRQ_FLAG]  = opFire & (|(raised & masks));
    assign irqEvent[`SFX_IRQ_FAULT] = opFire & (|unmasked);

    // sticky status, cleared by a read; a same-cycle event survives
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat <= {`SFX_IRQ_W{1'b0}};
        end else if (irqStRead) begin
            irqStat <= irqEvent;
        end else begin
            irqStat <= irqStat | irqEvent;
        end
    end

    // interrupt mask register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqMask <= {`SFX_IRQ_W{1'b0}};
        end else if (wbReq && wb_we_i && wb_sel_i[0] &&
                     (wb_adr_i[3:2] == `SFX_ADR_IRQMSK)) begin
            irqMask <= wb_dat_i[`SFX_IRQ_W-1:0];
        end
    end

    // level interrupt while any enabled event stands
    assign irq = |(irqStat & irqMask);

    // ack one cycle after request; read data captured with it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wbReq;
            if (wbReq && !wb_we_i) begin
                case (wb_adr_i[3:2])
                    `SFX_ADR_CS:     wb_dat_o <= {16'h0000, ctrlStat};
                    `SFX_ADR_IRQST:  wb_dat_o <= {30'h00000000, irqStat};
                    `SFX_ADR_IRQMSK: wb_dat_o <= {30'h00000000, irqMask};
                    `SFX_ADR_FAULT: begin
                        // cause, vector and count of the last fault
                        wb_dat_o <= {8'h00, faultCount, faultVector,
                                     2'b00, faultCause};
                    end
                    default:         wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // sfx_exc_signal

// *** sfx_regs.vh ***
// register map, field layout and opcode constants for the simd fp exception unit
`ifndef SFX_REGS_VH
`define SFX_REGS_VH

// exception class bit positions
`define SFX_CLS_W        6
`define SFX_CLS_INV      0
`define SFX_CLS_DEN      1
`define SFX_CLS_ZDV      2
`define SFX_CLS_OVF      3
`define SFX_CLS_UNF      4
`define SFX_CLS_PRE      5
`define SFX_CLS_NONE     6'h00
`define SFX_CLS_ALL      6'h3F
`define SFX_CLS_NOZDV    6'h3B
`define SFX_CLS_INVPRE   6'h21
`define SFX_CLS_INVONLY  6'h01

// lanes of a packed operation
`define SFX_LANES        4
`define SFX_LANE_ONE     4'h1

// control/status layout: flags low, masks above
`define SFX_FLAG_LSB     0
`define SFX_MASK_LSB     7
`define SFX_CS_W         16
`define SFX_CS_RESET     16'h1F80
`define SFX_CS_WMASK     16'h1FBF

// wishbone word offsets (byte address bits 3:2)
`define SFX_ADR_CS       2'h0
`define SFX_ADR_IRQST    2'h1
`define SFX_ADR_IRQMSK   2'h2
`define SFX_ADR_FAULT    2'h3

// interrupt status bits
`define SFX_IRQ_W        2
`define SFX_IRQ_FLAG     0
`define SFX_IRQ_FAULT    1

// fault information
`define SFX_FAULT_VEC    8'h13
`define SFX_VEC_LSB      8
`define SFX_CNT_LSB      16

// operation codes presented by the pipeline
`define SFX_OP_W         5
`define SFX_OP_GENERIC   5'h00
`define SFX_OP_NOFP      5'h01
`define SFX_OP_ADDSUB_PD 5'h02
`define SFX_OP_ADDSUB_PS 5'h03
`define SFX_OP_HADD_PD   5'h04
`define SFX_OP_HADD_PS   5'h05
`define SFX_OP_HSUB_PD   5'h06
`define SFX_OP_HSUB_PS   5'h07
`define SFX_OP_TRUNC_ST  5'h08
`define SFX_OP_GEN3_OTH  5'h09
`define SFX_OP_SUPP_INT  5'h0A
`define SFX_OP_DOT_PD    5'h0B
`define SFX_OP_DOT_PS    5'h0C
`define SFX_OP_ROUND_PD  5'h0D
`define SFX_OP_ROUND_PS  5'h0E
`define SFX_OP_ROUND_SD  5'h0F
`define SFX_OP_ROUND_SS  5'h10
`define SFX_OP_GEN4_OTH  5'h11
`define SFX_OP_RCP_SS    5'h12
`define SFX_OP_RCP_PS    5'h13
`define SFX_OP_RSQ_SS    5'h14
`define SFX_OP_RSQ_PS    5'h15

`endif

// *** sfx_class_filter.v ***
// per-operation filter of the exception classes an instruction may report
`timescale 1ns/1ns
`include "sfx_regs.vh"

module sfx_class_filter (
    // operation being retired
    input  wire [`SFX_OP_W-1:0]  opCode,
    input  wire                  immBit3,
    // classes this operation may report
    output reg  [`SFX_CLS_W-1:0] allowed
);

    // decode table; unknown codes report nothing rather than guess
    always @* begin
        case (opCode)
            // older arithmetic: every class may appear
            `SFX_OP_GENERIC:   allowed = `SFX_CLS_ALL;
            // alternating and horizontal add/sub: no divide-by-zero
            `SFX_OP_ADDSUB_PD: allowed = `SFX_CLS_NOZDV;
            `SFX_OP_ADDSUB_PS: allowed = `SFX_CLS_NOZDV;
            `SFX_OP_HADD_PD:   allowed = `SFX_CLS_NOZDV;
            `SFX_OP_HADD_PS:   allowed = `SFX_CLS_NOZDV;
            `SFX_OP_HSUB_PD:   allowed = `SFX_CLS_NOZDV;
            `SFX_OP_HSUB_PS:   allowed = `SFX_CLS_NOZDV;
            // truncating store: invalid and precision only
            `SFX_OP_TRUNC_ST:  allowed = `SFX_CLS_INVPRE;
            // dot products: no divide-by-zero
            `SFX_OP_DOT_PD:    allowed = `SFX_CLS_NOZDV;
            `SFX_OP_DOT_PS:    allowed = `SFX_CLS_NOZDV;
            // rounding: precision suppressed when immediate bit 3 is set
            `SFX_OP_ROUND_PD,
            `SFX_OP_ROUND_PS,
            `SFX_OP_ROUND_SD,
            `SFX_OP_ROUND_SS: begin
                allowed = immBit3 ? `SFX_CLS_INVONLY : `SFX_CLS_INVPRE;
            end
            // remaining third-generation ops
            `SFX_OP_GEN3_OTH:  allowed = `SFX_CLS_NONE;
            // supplemental group is integer only
            `SFX_OP_SUPP_INT:  allowed = `SFX_CLS_NONE;
            // remaining fourth-generation ops
            `SFX_OP_GEN4_OTH:  allowed = `SFX_CLS_NONE;
            // reciprocal approximations never raise numeric exceptions
            `SFX_OP_RCP_SS,
            `SFX_OP_RCP_PS,
            `SFX_OP_RSQ_SS,
            `SFX_OP_RSQ_PS:    allowed = `SFX_CLS_NONE;
            // non-fp work and unknown codes
            default:           allowed = `SFX_CLS_NONE;
        endcase
    end

endmodule // sfx_class_filter

// *** sfx_exc_chk.sv ***
// port-level assertions for the simd fp exception unit
`timescale 1ns/1ns
`include "sfx_regs.vh"

module sfx_exc_chk (
    // clock and reset
    input wire                  clk,
    input wire                  rst_n,
    // op path and completion
    input wire                  opValid,
    input wire                  opReady,
    input wire [`SFX_OP_W-1:0]  opCode,
    input wire                  immBit3,
    input wire                  doneValid,
    input wire                  destWrite,
    input wire                  faultTake,
    input wire [7:0]            faultVector,
    input wire [`SFX_CLS_W-1:0] faultCause,
    input wire                  trapAck
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // an op accepted at this edge
    sequence opTake;
        opValid && opReady;
    endsequence
    // fault pulse with the unit already closed to new ops
    sequence faultHold;
        faultTake ##0 !opReady;
    endsequence

    chk_done_follows: assert property (opTake |=> doneValid)
        else $error("op taken without completion next cycle");
    chk_fault_vector: assert property (faultTake |-> faultVector == `SFX_FAULT_VEC)
        else $error("fault taken with wrong vector");
    chk_fault_nowrite: assert property (faultTake |-> doneValid && !destWrite)
        else $error("faulting op wrote its destination");
    chk_masked_write: assert property (doneValid && !faultTake |-> destWrite)
        else $error("masked op lost its default result");
    chk_single_fault: assert property (faultTake |-> faultHold ##1 !faultTake)
        else $error("fault not held or taken twice");
    chk_hold_until: assert property (!opReady && !trapAck |=> !opReady)
        else $error("unit reopened before dispatch accepted the fault");
    // divide-by-zero never reaches the fault for these op classes
    chk_no_zdiv: assert property (faultTake && $past(opCode) inside
        {[`SFX_OP_ADDSUB_PD:`SFX_OP_HSUB_PS], `SFX_OP_DOT_PD, `SFX_OP_DOT_PS}
        |-> !faultCause[`SFX_CLS_ZDV])
        else $error("divide-by-zero fault from an op that cannot raise it");
    chk_quiet_ops: assert property (opTake ##0 opCode inside {`SFX_OP_NOFP, `SFX_OP_GEN3_OTH,
        `SFX_OP_SUPP_INT, [`SFX_OP_GEN4_OTH:`SFX_OP_RSQ_PS]} |=> !faultTake)
        else $error("fault from an op with no fp exceptions");
    // rounding faults only on invalid, and on precision when imm bit 3 is clear
    chk_round_cause: assert property (opTake ##0 opCode inside {[`SFX_OP_ROUND_PD:`SFX_OP_ROUND_SS]}
        |=> !faultTake || (faultCause & 6'h1E) == 6'h00 && !($past(immBit3) && faultCause[5]))
        else $error("rounding op faulted on a class it cannot raise");
endmodule // sfx_exc_chk

bind sfx_exc_signal sfx_exc_chk u_chk (.clk(clk), .rst_n(rst_n), .opValid(opValid),
    .opReady(opReady), .opCode(opCode), .immBit3(immBit3), .doneValid(doneValid),
    .destWrite(destWrite), .faultTake(faultTake), .faultVector(faultVector),
    .faultCause(faultCause), .trapAck(trapAck));

// *** sfx_pipe_model.sv ***
// trap dispatch model: accepts each taken fault after a chosen delay
`timescale 1ns/1ns

module sfx_pipe_model (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // fault side
    input  wire       faultTake,
    input  wire [3:0] ackDelay,
    output reg        trapAck
);
    reg [3:0] waitCnt; // cycles left before accepting
    reg       pending; // a fault waits for dispatch

    // one-cycle accept pulse; delay 0 answers promptly, larger ones stall
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
            waitCnt <= 4'h0;
            trapAck <= 1'b0;
        end else begin
            trapAck <= 1'b0;
            if (faultTake) begin
                pending <= 1'b1;
                waitCnt <= ackDelay;
            end else if (pending && waitCnt == 4'h0) begin
                pending <= 1'b0;
                trapAck <= 1'b1;
            end else if (pending) begin
                waitCnt <= waitCnt - 4'h1;
            end
        end
    end
endmodule // sfx_pipe_model

// *** tb_top.sv ***
// testbench for the simd fp exception unit
`timescale 1ns/1ns
`include "sfx_regs.vh"

module tb_top;
    reg         clk = 1'b0;
    reg         rst_n, opValid, immBit3, wb_cyc_i, wb_stb_i, wb_we_i;
    reg  [4:0]  opCode;
    reg  [3:0]  laneValid, wb_adr_i, wb_sel_i, ackDelay;
    reg  [23:0] laneExc;
    reg  [31:0] wb_dat_i, rd;   // rd: last read data
    reg         dv, dw, ft;     // completion sampled after an op
    wire        opReady, doneValid, destWrite, faultTake, trapAck, wb_ack_o, irq;
    wire [7:0]  faultVector;
    wire [5:0]  faultCause;
    wire [31:0] wb_dat_o;
    integer     fails, n_checks, i;
    reg  [4:0]  quiet [0:7];    // op classes that never raise

    always #25 clk = ~clk;

    sfx_exc_signal DUT (.clk(clk), .rst_n(rst_n), .opValid(opValid), .opReady(opReady),
        .opCode(opCode), .immBit3(immBit3), .laneValid(laneValid), .laneExc(laneExc),
        .doneValid(doneValid), .destWrite(destWrite), .faultTake(faultTake),
        .faultVector(faultVector), .faultCause(faultCause), .trapAck(trapAck),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq(irq));
    sfx_pipe_model u_pipe (.clk(clk), .rst_n(rst_n), .faultTake(faultTake),
        .ackDelay(ackDelay), .trapAck(trapAck));

    // compare and count
    task chk(input [31:0] seen, input [31:0] exp, input string what);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("ERROR %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    // classic wishbone cycle; ack and read data taken at the same edge
    task wb(input we, input [3:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i  <= we;
            wb_adr_i <= a;
            wb_dat_i <= d;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (wb_ack_o !== 1'b1 && n < 50);
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            if (n == 50) chk(0, 1, "wb ack");
        end
    endtask

    // one op for one cycle, completion sampled after the taking edge
    task op(input [4:0] c, input i3, input [3:0] lv, input [23:0] ex);
        begin
            @(posedge clk);
            opValid   <= 1'b1;
            opCode    <= c;
            immBit3   <= i3;
            laneValid <= lv;
            laneExc   <= ex;
            @(posedge clk);
            opValid <= 1'b0;
            #1;
            {dv, dw, ft} = {doneValid, destWrite, faultTake};
        end
    endtask

    // bounded wait for dispatch to reopen the unit
    task wait_ready;
        integer n;
        begin
            n = 0;
            while (opReady !== 1'b1 && n < 40) begin
                @(posedge clk);
                n = n + 1;
            end
            chk(opReady, 1, "opReady reopen");
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    initial begin
        #100000;
        fails = fails + 1;
        wrap_up;
    end

    initial begin
        {rst_n, opValid, immBit3, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h00;
        {opCode, laneValid, wb_adr_i, laneExc, wb_dat_i, ackDelay} = 0;
        wb_sel_i = 4'hF;
        fails = 0;
        n_checks = 0;
        quiet = '{`SFX_OP_NOFP, `SFX_OP_GEN3_OTH, `SFX_OP_SUPP_INT, `SFX_OP_GEN4_OTH,
                  `SFX_OP_RCP_SS, `SFX_OP_RCP_PS, `SFX_OP_RSQ_SS, `SFX_OP_RSQ_PS};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wb(0, 4'h0, 0);
        chk(rd, 32'h1F80, "ctrlStat reset");
        wb(0, 4'h8, 0);
        chk(rd, 0, "irqMask reset");
        // packed masked raise: lanes ored, inactive lane and divide-by-zero dropped
        op(`SFX_OP_ADDSUB_PS, 0, 4'h7, {6'h20, 6'h10, 6'h04, 6'h09});
        chk({dv, dw, ft}, 3'b110, "masked completion");
        wb(0, 4'h0, 0);
        chk(rd, 32'h1F99, "packed flags");
        wb(1, 4'h0, 32'h1F80);
        op(`SFX_OP_DOT_PD, 0, 4'h3, {18'h0, 6'h06});
        wb(0, 4'h0, 0);
        chk(rd, 32'h1F82, "dot flags");
        for (i = 0; i < 8; i = i + 1) begin
            wb(1, 4'h0, 32'h1F80);
            op(`SFX_OP_ROUND_PD + i[4:0] / 2, i[0], 4'h1, {18'h0, 6'h3F});
            wb(0, 4'h0, 0);
            chk(rd, i[0] ? 32'h1F81 : 32'h1FA1, "round flags");
        end
        // truncating store and generic arithmetic, every lane condition raised
        op(`SFX_OP_TRUNC_ST, 0, 4'h1, {18'h0, 6'h3F});
        chk({dv, dw, ft}, 3'b110, "trunc store completion");
        wb(0, 4'h0, 0);
        chk(rd, 32'h1FA1, "trunc store flags");
        op(`SFX_OP_GENERIC, 0, 4'h1, {18'h0, 6'h3F});
        wb(0, 4'h0, 0);
        chk(rd, 32'h1FBF, "generic flags");
        // divide-by-zero and overflow unmasked from here on
        wb(1, 4'h0, 32'h1980);
        for (i = 0; i < 8; i = i + 1) begin
            op(quiet[i], 0, 4'hF, 24'hFFFFFF);
            chk({dv, dw, ft}, 3'b110, "quiet op");
        end
        wb(0, 4'h0, 0);
        chk(rd, 32'h1980, "quiet flags");
        op(`SFX_OP_HADD_PD, 0, 4'h3, {12'h0, 6'h04, 6'h18});
        chk({dv, dw, ft}, 3'b101, "fault completion");
        chk(faultVector, 8'h13, "fault vector");
        chk(faultCause, 6'h08, "fault cause");
        chk(opReady, 0, "opReady hold");
        wait_ready;
        wb(0, 4'h0, 0);
        chk(rd, 32'h1998, "fault flags");
        op(`SFX_OP_ADDSUB_PD, 0, 4'h3, 24'h0);
        chk({dv, dw, ft}, 3'b110, "stale flag");
        op(`SFX_OP_ADDSUB_PD, 0, 4'h3, 24'h10);
        chk({dv, dw, ft}, 3'b110, "masked beside stale");
        ackDelay = 4'h5;
        op(`SFX_OP_DOT_PS, 0, 4'h1, 24'h08);
        repeat (3) @(posedge clk);
        chk(opReady, 0, "slow dispatch hold");
        wait_ready;
        wb(1, 4'hC, 32'hFFFFFFFF);
        wb(0, 4'hC, 0);
        chk(rd, 32'h00021308, "fault info");
        wb(0, 4'h4, 0);
        chk(rd, 32'h3, "irqStat events");
        wb(1, 4'h8, 32'h1);
        op(`SFX_OP_ADDSUB_PD, 0, 4'h1, 24'h10);
        chk(irq, 1, "irq raised");
        wb(0, 4'h4, 0);
        #1;
        chk(rd, 32'h1, "irqStat masked flag");
        chk(irq, 0, "irq cleared");
        wb(1, 4'h8, 32'h0);
        op(`SFX_OP_ADDSUB_PD, 0, 4'h1, 24'h10);
        chk(irq, 0, "irq masked");
        wrap_up;
    end
endmodule // tb_top
